/* common/ccu_pkg.sv */
package ccu_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] CCU_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] CCU_OFS_TB_LO = 8'h0e;
  localparam logic [7:0] CCU_OFS_TB_HI = 8'h0f;
  localparam logic [7:0] CCU_OFS_TB_CTRL = 8'h10;
  localparam logic [7:0] CCU_OFS_CH1_RES_LO = 8'h15;
  localparam logic [7:0] CCU_OFS_CH1_RES_HI = 8'h16;
  localparam logic [7:0] CCU_OFS_CH1_CTRL = 8'h17;
  localparam logic [7:0] CCU_OFS_CH2_RES_LO = 8'h1b;
  localparam logic [7:0] CCU_OFS_CH2_RES_HI = 8'h1c;
  localparam logic [7:0] CCU_OFS_CH2_CTRL = 8'h1d;

  // field positions
  localparam int CCU_FLAG_OVF_BIT = 0;
  localparam int CCU_FLAG_CH1_BIT = 2;
  localparam int CCU_FLAG_CH2_BIT = 3;
  localparam int CCU_TB_ON_BIT = 0;
  localparam int CCU_CTRL_DUTY1_BIT = 5;
  localparam int CCU_CTRL_DUTY0_BIT = 4;
  localparam int CCU_CTRL_MODE_MSB = 3;
  localparam int CCU_CTRL_WIDTH = 6;

  // reset values and the last count of the timebase
  localparam logic [5:0] CCU_CTRL_RESET = 6'h00;
  localparam logic [15:0] CCU_TB_RESET = 16'h0000;
  localparam logic [15:0] CCU_TB_LAST = 16'hffff;
  localparam logic [15:0] CCU_RES_RESET = 16'h0000;
  localparam logic [7:0] CCU_RDATA_RESET = 8'h00;

  // channel mode field codes
  localparam logic [3:0] CCU_MODE_OFF = 4'h0;
  localparam logic [3:0] CCU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] CCU_MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] CCU_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] CCU_MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] CCU_MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] CCU_MODE_CMP_TRIG = 4'hb;

  // prescaler counter width and the masks that mark every 4th and 16th edge
  localparam logic [3:0] CCU_PRESC_ZERO = 4'h0;
  localparam logic [3:0] CCU_PRESC_ONE = 4'h1;
  localparam logic [3:0] CCU_PRESC_MASK4 = 4'h3;
  localparam logic [3:0] CCU_PRESC_MASK16 = 4'hf;

  // capture modes are 01xx
  function automatic logic ccu_is_capture(input logic [3:0] mode);
    return mode[3:2] == 2'b01;
  endfunction

  // compare modes are 10xx
  function automatic logic ccu_is_compare(input logic [3:0] mode);
    return mode[3:2] == 2'b10;
  endfunction

  // pwm modes are 11xx
  function automatic logic ccu_is_pwm(input logic [3:0] mode);
    return mode[3:2] == 2'b11;
  endfunction

endpackage

/* hdl/ccu_channel.sv */
`timescale 1ns/1ps
module ccu_channel
  import ccu_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] mode,
  input wire logic mode_wr_off,
  input wire logic channel_pin,
  input wire logic [15:0] timebase,
  input wire logic timebase_on,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  output logic [15:0] result,
  output logic cmp_out,
  output logic event_pulse,
  output logic trigger_pulse
);

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [3:0] presc;
    logic [15:0] result;
    logic cmp_out;
    logic event_pulse;
    logic trigger_pulse;
  } ccu_ch_state_t;

  ccu_ch_state_t st;
  ccu_ch_state_t next_st;
  logic rise;
  logic fall;
  logic capture;
  logic match;
  logic [3:0] presc_inc;

  // edges seen on the synchronised pin; the pin level is watched, so a port write can capture
  assign rise = st.pin_sync & ~st.pin_prev;
  assign fall = st.pin_prev & ~st.pin_sync;
  assign presc_inc = st.presc + CCU_PRESC_ONE;
  // match only while the timebase is counting, so a stopped count does not flag forever
  assign match = ccu_is_compare(mode) && timebase_on && (st.result == timebase);

  // capture event select by mode field
  always_comb begin
    case (mode)
      CCU_MODE_CAP_FALL: capture = fall;
      CCU_MODE_CAP_RISE: capture = rise;
      CCU_MODE_CAP_RISE4: capture = rise && ((presc_inc & CCU_PRESC_MASK4) == CCU_PRESC_ZERO);
      CCU_MODE_CAP_RISE16: capture = rise && ((presc_inc & CCU_PRESC_MASK16) == CCU_PRESC_ZERO);
      default: capture = 1'b0;
    endcase
  end

  // next state of the channel
  always_comb begin
    next_st = st;
    next_st.pin_meta = channel_pin;
    next_st.pin_sync = st.pin_meta;
    next_st.pin_prev = st.pin_sync;
    next_st.event_pulse = 1'b0;
    next_st.trigger_pulse = 1'b0;
    // prescaler only lives in capture modes; a switch between capture modes keeps the count
    if (!ccu_is_capture(mode) || mode_wr_off) begin
      next_st.presc = CCU_PRESC_ZERO;
    end else if (rise) begin
      next_st.presc = presc_inc;
    end
    // software writes to the result bytes; a capture in the same cycle overrides them
    if (wr_lo) begin
      next_st.result[7:0] = wdata;
    end
    if (wr_hi) begin
      next_st.result[15:8] = wdata;
    end
    if (capture) begin
      next_st.result = timebase;
      next_st.event_pulse = 1'b1;
    end
    if (match) begin
      next_st.event_pulse = 1'b1;
      case (mode)
        CCU_MODE_CMP_SET: next_st.cmp_out = 1'b1;
        CCU_MODE_CMP_CLR: next_st.cmp_out = 1'b0;
        CCU_MODE_CMP_TRIG: next_st.trigger_pulse = 1'b1;
        default: next_st.cmp_out = st.cmp_out;
      endcase
    end
    // the off mode holds the output latch low
    if (mode == CCU_MODE_OFF || mode_wr_off) begin
      next_st.cmp_out = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign result = st.result;
  assign cmp_out = st.cmp_out;
  assign event_pulse = st.event_pulse;
  assign trigger_pulse = st.trigger_pulse;

endmodule

/* hdl/ccu_top.sv */
`timescale 1ns/1ps
module ccu_top
  import ccu_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic channel1_pin,
  input wire logic channel2_pin,
  output logic channel1_cmp_out,
  output logic channel2_cmp_out,
  input wire logic converter_enabled,
  output logic conversion_start,
  output logic timebase_overflow_flag,
  output logic channel1_event_flag,
  output logic channel2_event_flag
);

  typedef struct packed {
    logic [15:0] tb;
    logic tb_on;
    logic ovf;
    logic flag1;
    logic flag2;
    logic [5:0] ctrl1;
    logic [5:0] ctrl2;
    logic [7:0] rdata;
    logic conv_start;
    logic cmp1;
    logic cmp2;
  } ccu_state_t;

  ccu_state_t st;
  ccu_state_t next_st;

  // write decodes, one per register
  logic wr_flags;
  logic wr_tb_lo;
  logic wr_tb_hi;
  logic wr_tb_ctrl;
  logic wr_ch1_lo;
  logic wr_ch1_hi;
  logic wr_ch1_ctrl;
  logic wr_ch2_lo;
  logic wr_ch2_hi;
  logic wr_ch2_ctrl;

  // channel side signals
  logic [15:0] res1;
  logic [15:0] res2;
  logic cmp1;
  logic cmp2;
  logic ev1;
  logic ev2;
  logic trig1;
  logic trig2;
  logic off1;
  logic off2;
  logic tb_wrap;

  // true when a write strobe hits the given offset
  function automatic logic ccu_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  // address decode for writes
  always_comb begin
    wr_flags = ccu_hit(reg_wr, reg_addr, CCU_OFS_FLAGS);
    wr_tb_lo = ccu_hit(reg_wr, reg_addr, CCU_OFS_TB_LO);
    wr_tb_hi = ccu_hit(reg_wr, reg_addr, CCU_OFS_TB_HI);
    wr_tb_ctrl = ccu_hit(reg_wr, reg_addr, CCU_OFS_TB_CTRL);
    wr_ch1_lo = ccu_hit(reg_wr, reg_addr, CCU_OFS_CH1_RES_LO);
    wr_ch1_hi = ccu_hit(reg_wr, reg_addr, CCU_OFS_CH1_RES_HI);
    wr_ch1_ctrl = ccu_hit(reg_wr, reg_addr, CCU_OFS_CH1_CTRL);
    wr_ch2_lo = ccu_hit(reg_wr, reg_addr, CCU_OFS_CH2_RES_LO);
    wr_ch2_hi = ccu_hit(reg_wr, reg_addr, CCU_OFS_CH2_RES_HI);
    wr_ch2_ctrl = ccu_hit(reg_wr, reg_addr, CCU_OFS_CH2_CTRL);
  end

  // a control write of mode zero clears the channel prescaler and output latch in the same edge as the write
  assign off1 = wr_ch1_ctrl && (reg_wdata[CCU_CTRL_MODE_MSB:0] == CCU_MODE_OFF);
  assign off2 = wr_ch2_ctrl && (reg_wdata[CCU_CTRL_MODE_MSB:0] == CCU_MODE_OFF);

  // the counter rolls over only when it counts past its last value
  assign tb_wrap = st.tb_on && (st.tb == CCU_TB_LAST);

  // channel one: its trigger resets the timebase only
  ccu_channel u_ch1 (
    .mclk(mclk),
    .arst_n(arst_n),
    .mode(st.ctrl1[CCU_CTRL_MODE_MSB:0]),
    .mode_wr_off(off1),
    .channel_pin(channel1_pin),
    .timebase(st.tb),
    .timebase_on(st.tb_on),
    .wr_lo(wr_ch1_lo),
    .wr_hi(wr_ch1_hi),
    .wdata(reg_wdata),
    .result(res1),
    .cmp_out(cmp1),
    .event_pulse(ev1),
    .trigger_pulse(trig1)
  );

  // channel two: its trigger also starts a conversion
  ccu_channel u_ch2 (
    .mclk(mclk),
    .arst_n(arst_n),
    .mode(st.ctrl2[CCU_CTRL_MODE_MSB:0]),
    .mode_wr_off(off2),
    .channel_pin(channel2_pin),
    .timebase(st.tb),
    .timebase_on(st.tb_on),
    .wr_lo(wr_ch2_lo),
    .wr_hi(wr_ch2_hi),
    .wdata(reg_wdata),
    .result(res2),
    .cmp_out(cmp2),
    .event_pulse(ev2),
    .trigger_pulse(trig2)
  );

  // next state of the shared timebase, flags, control and read port
  always_comb begin
    next_st = st;
    next_st.conv_start = 1'b0;
    next_st.cmp1 = cmp1;
    next_st.cmp2 = cmp2;

    // free counting; the overflow set sits below the software clear so that a set wins
    if (st.tb_on) begin
      next_st.tb = st.tb + 16'h0001;
    end

    // trigger reset of the count keeps the overflow flag from setting in a wrap cycle
    if (trig1 || trig2) begin
      next_st.tb = CCU_TB_RESET;
    end
    // conversion starts only when the converter is enabled
    if (trig2 && converter_enabled) begin
      next_st.conv_start = 1'b1;
    end

    // software timebase writes come last so they beat a trigger reset
    if (wr_tb_lo) begin
      next_st.tb[7:0] = reg_wdata;
    end
    if (wr_tb_hi) begin
      next_st.tb[15:8] = reg_wdata;
    end
    if (wr_tb_ctrl) begin
      next_st.tb_on = reg_wdata[CCU_TB_ON_BIT];
    end

    // control registers; duty bits 5:4 are stored and read back but no mode uses them
    if (wr_ch1_ctrl) begin
      next_st.ctrl1 = reg_wdata[CCU_CTRL_WIDTH-1:0];
    end
    if (wr_ch2_ctrl) begin
      next_st.ctrl2 = reg_wdata[CCU_CTRL_WIDTH-1:0];
    end

    // flags clear by writing one; a hardware set in the same cycle wins
    if (wr_flags) begin
      if (reg_wdata[CCU_FLAG_OVF_BIT]) begin
        next_st.ovf = 1'b0;
      end
      if (reg_wdata[CCU_FLAG_CH1_BIT]) begin
        next_st.flag1 = 1'b0;
      end
      if (reg_wdata[CCU_FLAG_CH2_BIT]) begin
        next_st.flag2 = 1'b0;
      end
    end
    if (tb_wrap && !(trig1 || trig2)) begin
      next_st.ovf = 1'b1;
    end
    if (ev1) begin
      next_st.flag1 = 1'b1;
    end
    if (ev2) begin
      next_st.flag2 = 1'b1;
    end

    // read data stand only in the cycle after the read strobe
    next_st.rdata = CCU_RDATA_RESET;
    if (reg_rd) begin
      case (reg_addr)
        CCU_OFS_FLAGS: begin
          next_st.rdata[CCU_FLAG_OVF_BIT] = st.ovf;
          next_st.rdata[CCU_FLAG_CH1_BIT] = st.flag1;
          next_st.rdata[CCU_FLAG_CH2_BIT] = st.flag2;
        end
        CCU_OFS_TB_LO: next_st.rdata = st.tb[7:0];
        CCU_OFS_TB_HI: next_st.rdata = st.tb[15:8];
        CCU_OFS_TB_CTRL: next_st.rdata[CCU_TB_ON_BIT] = st.tb_on;
        CCU_OFS_CH1_RES_LO: next_st.rdata = res1[7:0];
        CCU_OFS_CH1_RES_HI: next_st.rdata = res1[15:8];
        CCU_OFS_CH1_CTRL: next_st.rdata = {2'b00, st.ctrl1};
        CCU_OFS_CH2_RES_LO: next_st.rdata = res2[7:0];
        CCU_OFS_CH2_RES_HI: next_st.rdata = res2[15:8];
        CCU_OFS_CH2_CTRL: next_st.rdata = {2'b00, st.ctrl2};
        default: next_st.rdata = CCU_RDATA_RESET;
      endcase
    end
  end

  // state register for the timebase, flags, control, read data and outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs from flops
  assign reg_rdata = st.rdata;
  assign channel1_cmp_out = st.cmp1;
  assign channel2_cmp_out = st.cmp2;
  assign conversion_start = st.conv_start;
  assign timebase_overflow_flag = st.ovf;
  assign channel1_event_flag = st.flag1;
  assign channel2_event_flag = st.flag2;

endmodule

/* testbench/ccu_top_chk.sv */
`timescale 1ns/1ps
module ccu_top_chk
  import ccu_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic channel1_cmp_out,
  input wire logic channel2_cmp_out,
  input wire logic converter_enabled,
  input wire logic conversion_start,
  input wire logic channel1_event_flag,
  input wire logic channel2_event_flag
);
  logic clr1;
  logic clr2;
  // software flag clears, the only cause allowed to drop a sticky flag
  assign clr1 = reg_wr && reg_addr == CCU_OFS_FLAGS && reg_wdata[CCU_FLAG_CH1_BIT];
  assign clr2 = reg_wr && reg_addr == CCU_OFS_FLAGS && reg_wdata[CCU_FLAG_CH2_BIT];
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // read data stand for one cycle only
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero after idle cycle");
  AST_CTRL_TOP_BITS: assert property ((reg_rd && (reg_addr == CCU_OFS_CH1_CTRL ||
    reg_addr == CCU_OFS_CH2_CTRL)) |=> reg_rdata[7:6] == 2'b00)
    else $error("control bits 7:6 not zero");
  AST_UNMAPPED_READ: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // flags may lag the clear by one register stage
  AST_FLAG1_STICKY: assert property ($fell(channel1_event_flag) |-> $past(clr1) || $past(clr1, 2))
    else $error("channel 1 flag dropped without clear");
  AST_FLAG2_STICKY: assert property (channel2_event_flag && !clr2 && !$past(clr2) |=> channel2_event_flag)
    else $error("channel 2 flag dropped without clear");
  // latch clears at the write edge, the port follows one cycle later
  AST_CMP1_OFF: assert property (reg_wr && reg_addr == CCU_OFS_CH1_CTRL && reg_wdata[3:0] == CCU_MODE_OFF
    |-> ##2 !channel1_cmp_out)
    else $error("channel 1 output not low after off");
  AST_CMP2_OFF: assert property (reg_wr && reg_addr == CCU_OFS_CH2_CTRL && reg_wdata[3:0] == CCU_MODE_OFF
    |-> ##2 !channel2_cmp_out)
    else $error("channel 2 output not low after off");
  AST_CONV_PULSE: assert property (conversion_start |=> !conversion_start)
    else $error("conversion start longer than one cycle");
  AST_CONV_GATED: assert property (!converter_enabled [*3] |=> !conversion_start)
    else $error("conversion start while converter disabled");
endmodule

/* testbench/ccu_pin_src.sv */
`timescale 1ns/1ps
module ccu_pin_src (
  input wire logic mclk,
  output logic pin
);
  initial pin = 1'b0;
  // each level is held six cycles so the two-flop synchroniser cannot miss it
  task automatic level(input logic l);
    pin <= l;
    repeat (6) @(posedge mclk);
  endtask
  // whole high/low pulses, one rising and one falling edge each
  task automatic pulse(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule

/* testbench/ccu_top_tb.sv */
`timescale 1ns/1ps
module ccu_top_tb
  import ccu_pkg::*;
;
  localparam logic [7:0] ctl1 = CCU_OFS_CH1_CTRL;
  localparam logic [7:0] flg = CCU_OFS_FLAGS;
  logic mclk;
  logic arst_n;
  logic reg_wr;
  logic reg_rd;
  logic converter_enabled;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic channel1_pin;
  logic channel2_pin;
  logic channel1_cmp_out;
  logic channel2_cmp_out;
  logic conversion_start;
  logic timebase_overflow_flag;
  logic channel1_event_flag;
  logic channel2_event_flag;
  int n_errors = 0;
  int n_compared = 0;
  int n_conv = 0;
  ccu_top dut_u (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel1_pin(channel1_pin),
    .channel2_pin(channel2_pin), .channel1_cmp_out(channel1_cmp_out), .channel2_cmp_out(channel2_cmp_out),
    .converter_enabled(converter_enabled), .conversion_start(conversion_start),
    .timebase_overflow_flag(timebase_overflow_flag), .channel1_event_flag(channel1_event_flag),
    .channel2_event_flag(channel2_event_flag));
  ccu_pin_src p1_u (.mclk(mclk), .pin(channel1_pin));
  ccu_pin_src p2_u (.mclk(mclk), .pin(channel2_pin));
  // clock and a count of conversion start pulses
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (conversion_start === 1'b1) n_conv <= n_conv + 1;
  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // values are taken at the call, so callers pass only what settled an edge or more ago
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // register port: one-cycle strobes, a gap cycle so strobes never get assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // read data stand only in the cycle after the strobe, so they are taken inside it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic res1(input logic [15:0] e);
    rchk("res lo", CCU_OFS_CH1_RES_LO, e[7:0]);
    rchk("res hi", CCU_OFS_CH1_RES_HI, e[15:8]);
  endtask
  // a stopped timebase makes every captured value exact
  task automatic set_tb(input logic [15:0] v, input logic [7:0] on);
    wr(CCU_OFS_TB_CTRL, 8'h00);
    wr(CCU_OFS_TB_LO, v[7:0]);
    wr(CCU_OFS_TB_HI, v[15:8]);
    wr(CCU_OFS_TB_CTRL, on);
  endtask
  task automatic mode1(input logic [3:0] m);
    wr(ctl1, 8'h00);
    wr(ctl1, {4'h0, m});
    wr(flg, 8'h0d);
  endtask
  // timebase from zero, then wait a bounded time for a match flag
  task automatic cmp_run(input logic [7:0] ca, input logic [3:0] m);
    set_tb(16'h0000, 8'h00);
    wr(ca, {4'h0, m});
    wr(flg, 8'h0d);
    wr(CCU_OFS_TB_CTRL, 8'h01);
    for (int i = 0; i < 300 && (channel1_event_flag | channel2_event_flag) !== 1'b1; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_regs();
    rchk("ctrl1 reset", ctl1, 8'h00);
    rchk("ctrl2 reset", CCU_OFS_CH2_CTRL, 8'h00);
    rchk("res reset", CCU_OFS_CH1_RES_LO, 8'h00);
    wr(CCU_OFS_CH2_CTRL, 8'hf0);
    rchk("ctrl2 duty", CCU_OFS_CH2_CTRL, 8'h30);
    wr(CCU_OFS_CH2_CTRL, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
  endtask
  task automatic t_capture();
    set_tb(16'h1234, 8'h00);
    mode1(CCU_MODE_CAP_RISE);
    p1_u.pulse(1);
    chk("rise flag", 1'b1, channel1_event_flag);
    res1(16'h1234);
    set_tb(16'habcd, 8'h00);
    p1_u.pulse(1);
    res1(16'habcd);
    chk("flag kept", 1'b1, channel1_event_flag);
    mode1(CCU_MODE_CAP_FALL);
    p1_u.level(1'b1);
    chk("fall mode rise", 1'b0, channel1_event_flag);
    p1_u.level(1'b0);
    chk("fall mode fall", 1'b1, channel1_event_flag);
  endtask
  task automatic t_presc();
    for (int i = 0; i < 2; i++) begin
      mode1((i == 0) ? CCU_MODE_CAP_RISE4 : CCU_MODE_CAP_RISE16);
      p1_u.pulse((i == 0) ? 3 : 15);
      chk("prescale early", 1'b0, channel1_event_flag);
      p1_u.pulse(1);
      chk("prescale due", 1'b1, channel1_event_flag);
    end
    mode1(CCU_MODE_CAP_RISE16);
    p1_u.pulse(3);
    wr(ctl1, {4'h0, CCU_MODE_CAP_RISE4});
    wr(flg, 8'h0d);
    p1_u.pulse(1);
    chk("switch keeps count", 1'b1, channel1_event_flag);
    p1_u.pulse(1);
    wr(ctl1, {4'h0, CCU_MODE_CMP_SOFT});
    wr(ctl1, {4'h0, CCU_MODE_CAP_RISE4});
    wr(flg, 8'h0d);
    p1_u.pulse(3);
    chk("compare clears count", 1'b0, channel1_event_flag);
  endtask
  task automatic t_compare();
    wr(ctl1, 8'h00);
    wr(CCU_OFS_CH1_RES_LO, 8'h20);
    wr(CCU_OFS_CH1_RES_HI, 8'h00);
    cmp_run(ctl1, CCU_MODE_CMP_SET);
    chk("set out", 1'b1, channel1_cmp_out);
    chk("set flag", 1'b1, channel1_event_flag);
    cmp_run(ctl1, CCU_MODE_CMP_SOFT);
    chk("soft out", 1'b1, channel1_cmp_out);
    chk("soft flag", 1'b1, channel1_event_flag);
    cmp_run(ctl1, CCU_MODE_CMP_CLR);
    chk("clr out", 1'b0, channel1_cmp_out);
    cmp_run(ctl1, CCU_MODE_CMP_SET);
    wr(ctl1, 8'h00);
    @(posedge mclk); // the port follows the latch one edge later
    chk("off out", 1'b0, channel1_cmp_out);
  endtask
  // channel 1 trigger, channel 2 with converter off, then on
  task automatic t_trigger();
    logic [7:0] ca;
    logic [7:0] d;
    int c0;
    for (int i = 0; i < 3; i++) begin
      ca = (i == 0) ? ctl1 : CCU_OFS_CH2_CTRL;
      converter_enabled <= (i == 2);
      wr(ca, 8'h00);
      wr(ca - 8'h02, 8'h40);
      wr(ca - 8'h01, 8'h00);
      c0 = n_conv;
      cmp_run(ca, CCU_MODE_CMP_TRIG);
      rchk("tb restarted", CCU_OFS_TB_HI, 8'h00);
      rd(CCU_OFS_TB_LO, d);
      chk("tb low small", 1'b1, d < 8'h40);
      chk("trig pin", 1'b0, channel1_cmp_out);
      chk("conversion", (i == 2), n_conv != c0);
      chk("no overflow", 1'b0, timebase_overflow_flag);
      wr(ca, 8'h00);
    end
  endtask
  // channel 2 capture and compare on its own pin, then a real timebase wrap
  task automatic t_ch2();
    logic [7:0] c2;
    c2 = CCU_OFS_CH2_CTRL;
    set_tb(16'h5aa5, 8'h00);
    wr(c2, 8'h00);
    wr(c2, {4'h0, CCU_MODE_CAP_RISE});
    wr(flg, 8'h0d);
    p2_u.pulse(1);
    chk("ch2 flag", 1'b1, channel2_event_flag);
    chk("ch1 flag quiet", 1'b0, channel1_event_flag);
    rchk("ch2 res lo", CCU_OFS_CH2_RES_LO, 8'ha5);
    rchk("ch2 res hi", CCU_OFS_CH2_RES_HI, 8'h5a);
    wr(CCU_OFS_CH2_RES_LO, 8'h10);
    wr(CCU_OFS_CH2_RES_HI, 8'h00);
    cmp_run(c2, CCU_MODE_CMP_SET);
    chk("ch2 set out", 1'b1, channel2_cmp_out);
    chk("ch2 set flag", 1'b1, channel2_event_flag);
    chk("ch1 out quiet", 1'b0, channel1_cmp_out);
    wr(c2, 8'h00);
    @(posedge mclk);
    chk("ch2 off out", 1'b0, channel2_cmp_out);
    set_tb(16'hfff0, 8'h01);
    repeat (20) @(posedge mclk);
    chk("wrap overflow", 1'b1, timebase_overflow_flag);
    wr(flg, 8'h01);
    chk("overflow cleared", 1'b0, timebase_overflow_flag);
  endtask
  // reset, then every scenario in turn
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    converter_enabled = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_capture();
    t_presc();
    t_compare();
    t_trigger();
    t_ch2();
    results();
  end
  // the sequence needs roughly a thousand cycles; this leaves ample margin
  initial begin
    #250000;
    n_errors++;
    results();
  end
endmodule
bind ccu_top ccu_top_chk chk_u (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel1_cmp_out(channel1_cmp_out),
  .channel2_cmp_out(channel2_cmp_out), .converter_enabled(converter_enabled),
  .conversion_start(conversion_start), .channel1_event_flag(channel1_event_flag),
  .channel2_event_flag(channel2_event_flag));
